// >>> rtl/pwmdc_pkg.sv
// constants for the pwm duty compare and clock select block
package pwmdc_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CLK_JOIN = 8'h00;
   localparam logic [7:0] ADDR_POL_PICK = 8'h01;
   localparam logic [7:0] ADDR_SCALE = 8'h02;
   localparam logic [7:0] ADDR_ENABLE = 8'h03;
   localparam logic [7:0] ADDR_COUNTER0 = 8'h04;
   localparam logic [7:0] ADDR_PERIOD0 = 8'h08;
   localparam logic [7:0] ADDR_DUTY0 = 8'h0C;
   // clock_and_join_control fields
   localparam int JOIN_CH3_CH4_BIT = 7;
   localparam int JOIN_CH1_CH2_BIT = 6;
   localparam int CLK_A_RATE_HI_BIT = 5;
   localparam int CLK_A_RATE_LO_BIT = 4;
   localparam int CLK_B_RATE_B2_BIT = 2;
   localparam int CLK_B_RATE_B0_BIT = 0;
   // polarity / clock pick register fields
   localparam int START_LEVEL_LSB = 0;
   localparam int SCALED_PICK_LSB = 4;
   // reset values
   localparam logic [7:0] DUTY_RESET = 8'hFF;
   localparam logic [7:0] PERIOD_RESET = 8'hFF;
   localparam logic [7:0] CLK_JOIN_RESET = 8'h00;
   localparam logic [7:0] POL_PICK_RESET = 8'h00;
   localparam logic [7:0] SCALE_RESET = 8'h00;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] COUNTER_RESET = 8'h00;
   // prescaler geometry
   localparam int RATE_W = 3;
   localparam int PRESCALE_W = 7;
endpackage

// >>> rtl/pwmdc_rate_if.sv
// rate select and tick pair between the block and a prescaler
`timescale 1ns/10ps
`default_nettype none
interface pwmdc_rate_if;
   logic [pwmdc_pkg::RATE_W-1:0] rate;
   logic tick;
   modport prescale (input rate, output tick);
   modport user (output rate, input tick);
endinterface
`default_nettype wire

// >>> rtl/pwmdc_prescale.sv
// free running power of two prescaler giving a one cycle tick enable
`timescale 1ns/10ps
`default_nettype none
module pwmdc_prescale (
   input wire logic sys_clk,
   input wire logic rst_n,
   pwmdc_rate_if.prescale rif
);
   logic [pwmdc_pkg::PRESCALE_W-1:0] div_reg;
   logic [pwmdc_pkg::PRESCALE_W-1:0] mask;
   logic tick_reg;

   ////////////////////////////////////////////////////////////////////////
   // mask of low bits that must all be ones, rate n gives E/2^n
   always_comb begin
      mask = pwmdc_pkg::PRESCALE_W'((8'h01 << rif.rate) - 8'h01);
   end

   // divider runs freely; a rate change may shorten one tick period
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   // tick when all selected low bits are ones
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= ((div_reg & mask) == mask);
      end
   end

   assign rif.tick = tick_reg;
endmodule
`default_nettype wire

// >>> rtl/pwmdc_top.sv
// four channel pwm duty compare, pair joining and clock prescale selection
//
// Operation
// - each of four channels owns a duty register setting its duty cycle
// - buffered duty compared against channel counter; output changes on match
// - duty buffer reloads only when counter clears, by period end or write
// - duty writes accepted anytime; new value applies from next pwm cycle
// - duty register reads return last written value, not the buffer
// - duty at or above period gives no transition; start level held
// - duty zero with nonzero period holds output at the changed-to level permanently
// - join bit for channels 3/4 makes one 16-bit channel, 3 high byte
// - joined 3/4 waveform appears on channel 4 output, pin bit 3
// - join 3/4 clear means two independent 8-bit channels
// - join bit for channels 1/2 makes one 16-bit channel, 1 high byte
// - joined 1/2 waveform appears on channel 2 output, pin bit 1
// - join 1/2 clear means two independent 8-bit channels
// - clock A is a source for channels 1 and 2
// - clock A is E, E/2, E/4 or E/8 from a two bit field
// - clock B is a source for channels 3 and 4
// - clock B is E divided by 2^n, n from a three bit field
// - counter clears and new cycle begins when counter matches period buffer
// - start level high when polarity one, low when zero; flips at duty
// - each channel picks clock A/B or scaled clock by its pick bit
// - joined writes go high then low byte; no reload in between
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
module pwmdc_top (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   output logic [3:0] pwm_out,
   output logic [3:0] pwm_oe
);
   logic [7:0] clk_join_reg;
   logic [7:0] pol_pick_reg;
   logic [7:0] scale_reg;
   logic [7:0] scale_cnt_reg;
   logic s_half_reg;
   logic s_tick_reg;
   logic [3:0] enable_reg;
   logic [7:0] cnt_reg [4];
   logic [7:0] per_reg [4];
   logic [7:0] per_buf_reg [4];
   logic [7:0] duty_reg [4];
   logic [7:0] duty_buf_reg [4];
   logic [3:0] past_reg;
   logic [1:0] pend_reg;
   logic [7:0] rd_data_reg;
   logic [3:0] out_reg;
   logic [3:0] oe_reg;
   logic [1:0] join_pair;
   logic [3:0] tick;
   logic [3:0] cnt_wr;
   logic [3:0] per_wr;
   logic [3:0] duty_wr;
   logic [15:0] cnt_v [4];
   logic [15:0] per_v [4];
   logic [15:0] duty_v [4];
   logic [3:0] hit_per;
   logic [3:0] hit_duty;
   logic [3:0] clear_ch;
   logic [3:0] reload_ok;
   logic [3:0] level;
   logic [3:0] pol;
   logic [3:0] pick;
   logic [7:0] s_next;

   pwmdc_rate_if rate_a ();
   pwmdc_rate_if rate_b ();

   ////////////////////////////////////////////////////////////////////////
   // prescaled clocks A and B from the bus clock
   assign rate_a.rate = {1'b0, clk_join_reg[pwmdc_pkg::CLK_A_RATE_HI_BIT],
                         clk_join_reg[pwmdc_pkg::CLK_A_RATE_LO_BIT]};
   assign rate_b.rate = clk_join_reg[pwmdc_pkg::CLK_B_RATE_B2_BIT:
                                     pwmdc_pkg::CLK_B_RATE_B0_BIT];

   pwmdc_prescale u_clk_a (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .rif(rate_a)
   );

   pwmdc_prescale u_clk_b (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .rif(rate_b)
   );

   ////////////////////////////////////////////////////////////////////////
   // decoded bus strobes
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         cnt_wr[c] = wr_en && (addr == pwmdc_pkg::ADDR_COUNTER0 + 8'(c));
         per_wr[c] = wr_en && (addr == pwmdc_pkg::ADDR_PERIOD0 + 8'(c));
         duty_wr[c] = wr_en && (addr == pwmdc_pkg::ADDR_DUTY0 + 8'(c));
      end
   end

   assign join_pair = {clk_join_reg[pwmdc_pkg::JOIN_CH3_CH4_BIT],
                       clk_join_reg[pwmdc_pkg::JOIN_CH1_CH2_BIT]};
   assign pol = pol_pick_reg[pwmdc_pkg::START_LEVEL_LSB +: 4];
   assign pick = pol_pick_reg[pwmdc_pkg::SCALED_PICK_LSB +: 4];

   ////////////////////////////////////////////////////////////////////////
   // control register writes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_join_reg <= pwmdc_pkg::CLK_JOIN_RESET;
         pol_pick_reg <= pwmdc_pkg::POL_PICK_RESET;
         scale_reg <= pwmdc_pkg::SCALE_RESET;
         enable_reg <= pwmdc_pkg::ENABLE_RESET[3:0];
      end else if (wr_en) begin
         if (addr == pwmdc_pkg::ADDR_CLK_JOIN) begin
            clk_join_reg <= wr_data & 8'hF7; // bit 3 unused
         end
         if (addr == pwmdc_pkg::ADDR_POL_PICK) begin
            pol_pick_reg <= wr_data;
         end
         if (addr == pwmdc_pkg::ADDR_SCALE) begin
            scale_reg <= wr_data;
         end
         if (addr == pwmdc_pkg::ADDR_ENABLE) begin
            enable_reg <= wr_data[3:0];
         end
      end
   end

   // software copies of period and duty, kept apart from the buffers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int c = 0; c < 4; c++) begin
            per_reg[c] <= pwmdc_pkg::PERIOD_RESET;
            duty_reg[c] <= pwmdc_pkg::DUTY_RESET;
         end
      end else begin
         for (int c = 0; c < 4; c++) begin
            if (per_wr[c]) begin
               per_reg[c] <= wr_data;
            end
            if (duty_wr[c]) begin
               duty_reg[c] <= wr_data;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // scaled clock: A divided by scale value then by two; zero means 256
   assign s_next = scale_cnt_reg + 8'h01;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scale_cnt_reg <= 8'h00;
         s_half_reg <= 1'b0;
         s_tick_reg <= 1'b0;
      end else begin
         s_tick_reg <= 1'b0;
         if (wr_en && addr == pwmdc_pkg::ADDR_SCALE) begin
            // restart so a faster rate is not missed by a high count
            scale_cnt_reg <= 8'h00;
         end else if (rate_a.tick) begin
            if (s_next == scale_reg) begin
               scale_cnt_reg <= 8'h00;
               s_half_reg <= ~s_half_reg;
               s_tick_reg <= s_half_reg;
            end else begin
               scale_cnt_reg <= s_next;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per channel clock enables
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         if (pick[c]) begin
            tick[c] = enable_reg[c] && s_tick_reg;
         end else if (c < 2) begin
            tick[c] = enable_reg[c] && rate_a.tick;
         end else begin
            tick[c] = enable_reg[c] && rate_b.tick;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // 16-bit views: a joined low channel sees the pair, high byte first
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         if (join_pair[c / 2] && c[0]) begin
            cnt_v[c] = {cnt_reg[c - 1], cnt_reg[c]};
            per_v[c] = {per_buf_reg[c - 1], per_buf_reg[c]};
            duty_v[c] = {duty_buf_reg[c - 1], duty_buf_reg[c]};
         end else begin
            cnt_v[c] = {8'h00, cnt_reg[c]};
            per_v[c] = {8'h00, per_buf_reg[c]};
            duty_v[c] = {8'h00, duty_buf_reg[c]};
         end
         hit_per[c] = tick[c] && (cnt_v[c] == per_v[c]);
         hit_duty[c] = tick[c] && (cnt_v[c] == duty_v[c]);
      end
   end

   // clear events; a joined high channel follows its low partner
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         if (join_pair[c / 2]) begin
            clear_ch[c] = hit_per[c | 1] || cnt_wr[c | 1];
            reload_ok[c] = !pend_reg[c / 2];
         end else begin
            clear_ch[c] = hit_per[c] || cnt_wr[c];
            reload_ok[c] = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // high byte written, low byte not yet: hold the buffers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg <= 2'b00;
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (duty_wr[2 * p + 1] || per_wr[2 * p + 1] || !join_pair[p]) begin
               pend_reg[p] <= 1'b0;
            end else if (duty_wr[2 * p] || per_wr[2 * p]) begin
               pend_reg[p] <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counters; joined pair counts as one, high byte write has no effect
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int c = 0; c < 4; c++) begin
            cnt_reg[c] <= pwmdc_pkg::COUNTER_RESET;
         end
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (join_pair[p]) begin
               if (clear_ch[2 * p + 1]) begin
                  cnt_reg[2 * p] <= 8'h00;
                  cnt_reg[2 * p + 1] <= 8'h00;
               end else if (tick[2 * p + 1]) begin
                  {cnt_reg[2 * p], cnt_reg[2 * p + 1]} <= cnt_v[2 * p + 1] + 16'h0001;
               end
            end else begin
               for (int k = 2 * p; k < 2 * p + 2; k++) begin
                  if (clear_ch[k]) begin
                     cnt_reg[k] <= 8'h00;
                  end else if (tick[k]) begin
                     cnt_reg[k] <= cnt_reg[k] + 8'h01;
                  end
               end
            end
         end
      end
   end

   // compare buffers load only when the counter clears
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int c = 0; c < 4; c++) begin
            per_buf_reg[c] <= pwmdc_pkg::PERIOD_RESET;
            duty_buf_reg[c] <= pwmdc_pkg::DUTY_RESET;
         end
      end else begin
         for (int c = 0; c < 4; c++) begin
            if (clear_ch[c] && reload_ok[c]) begin
               per_buf_reg[c] <= per_reg[c];
               duty_buf_reg[c] <= duty_reg[c];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // duty match seen this cycle; cleared at every new cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         past_reg <= 4'h0;
      end else begin
         for (int c = 0; c < 4; c++) begin
            if (clear_ch[c]) begin
               past_reg[c] <= 1'b0;
            end else if (hit_duty[c]) begin
               past_reg[c] <= 1'b1;
            end
         end
      end
   end

   // level with boundary cases; joined pair takes low channel settings
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         if (per_v[c] == 16'h0000) begin
            level[c] = pol[c];
         end else if (duty_v[c] == 16'h0000) begin
            level[c] = ~pol[c];
         end else if (duty_v[c] >= per_v[c]) begin
            level[c] = pol[c];
         end else begin
            level[c] = past_reg[c] ? ~pol[c] : pol[c];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // port lines: joined output on the low channel pin, high pin idle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_reg <= 4'h0;
         oe_reg <= 4'h0;
      end else begin
         for (int c = 0; c < 4; c++) begin
            if (join_pair[c / 2] && !c[0]) begin
               out_reg[c] <= pol[c];
               oe_reg[c] <= 1'b0;
            end else begin
               out_reg[c] <= level[c];
               oe_reg[c] <= enable_reg[c];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data in the cycle after the strobe only
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_reg <= 8'h00;
      end else if (!rd_en) begin
         rd_data_reg <= 8'h00;
      end else if (addr == pwmdc_pkg::ADDR_CLK_JOIN) begin
         rd_data_reg <= clk_join_reg;
      end else if (addr == pwmdc_pkg::ADDR_POL_PICK) begin
         rd_data_reg <= pol_pick_reg;
      end else if (addr == pwmdc_pkg::ADDR_SCALE) begin
         rd_data_reg <= scale_reg;
      end else if (addr == pwmdc_pkg::ADDR_ENABLE) begin
         rd_data_reg <= {4'h0, enable_reg};
      end else if (addr[7:2] == pwmdc_pkg::ADDR_COUNTER0[7:2]) begin
         rd_data_reg <= cnt_reg[addr[1:0]];
      end else if (addr[7:2] == pwmdc_pkg::ADDR_PERIOD0[7:2]) begin
         rd_data_reg <= per_reg[addr[1:0]];
      end else if (addr[7:2] == pwmdc_pkg::ADDR_DUTY0[7:2]) begin
         rd_data_reg <= duty_reg[addr[1:0]];
      end else begin
         rd_data_reg <= 8'h00; // unmapped reads as zero
      end
   end

   assign rd_data = rd_data_reg;
   assign pwm_out = out_reg;
   assign pwm_oe = oe_reg;
endmodule
`default_nettype wire

// >>> test/pwmdc_top_chk.sv
// port level assertions for the pwm duty compare block
`timescale 1ns/10ps
`default_nettype none
module pwmdc_top_chk (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] rd_data,
   input wire logic [3:0] pwm_out,
   input wire logic [3:0] pwm_oe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] sh_reg [16];
   logic [9:0] quiet_reg;
   logic j12, j34, ch1_on, ch1_plain;
   // shadow of software writes; counter slots unused since writes clear them
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 16; i++) begin
            sh_reg[i] <= (i >= 8) ? 8'hFF : 8'h00;
         end
      end else if (wr_en && addr < 8'h10) begin
         sh_reg[addr[3:0]] <= wr_data;
      end
   end
   // quiet time since last write; 600 cycles covers a reload at full rate
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet_reg <= 10'h000;
      end else if (wr_en) begin
         quiet_reg <= 10'h000;
      end else if (quiet_reg != 10'h3FF) begin
         quiet_reg <= quiet_reg + 10'h001;
      end
   end
   // channel 1 alone, enabled, clock a at full rate
   assign j12 = sh_reg[0][6];
   assign j34 = sh_reg[0][7];
   assign ch1_on = !j12 && sh_reg[3][0];
   assign ch1_plain = ch1_on && quiet_reg >= 10'h258 && sh_reg[0][5:4] == 2'b00 && !sh_reg[1][4];
   ////////////////////////////////////////////////////////////////////////////////
   rd_idle_zero_a: assert property (!$past(rd_en) |-> rd_data == 8'h00)
      else $error("read data not zero outside a read");
   duty_readback_a: assert property (rd_en && addr[7:2] == 6'h03 |=>
      rd_data == $past(sh_reg[addr[3:0]])) else $error("duty read is not last write");
   ctrl_readback_a: assert property (rd_en && addr == pwmdc_pkg::ADDR_CLK_JOIN |=>
      rd_data == ($past(sh_reg[0]) & 8'hF7)) else $error("control read mismatch");
   join12_pin_a: assert property (j12 && $past(j12) && $past(j12, 2) |-> !pwm_oe[0])
      else $error("joined high channel 1 pin driven");
   join34_pin_a: assert property (j34 && $past(j34) && $past(j34, 2) |-> !pwm_oe[2])
      else $error("joined high channel 3 pin driven");
   ch1_drive_a: assert property (ch1_on && $past(ch1_on) && $past(ch1_on, 2) |-> pwm_oe[0])
      else $error("independent channel 1 pin not driven");
   duty_zero_a: assert property (ch1_plain && sh_reg[12] == 8'h00 && sh_reg[8] != 8'h00
      |-> pwm_out[0] == !sh_reg[1][0]) else $error("zero duty level wrong");
   duty_full_a: assert property (ch1_plain && (sh_reg[8] == 8'h00 ||
      (sh_reg[12] != 8'h00 && sh_reg[12] >= sh_reg[8])) |-> pwm_out[0] == sh_reg[1][0])
      else $error("duty at or above period toggled");
endmodule
`default_nettype wire

// >>> test/pwmdc_top_tb.sv
// self-checking bench for the pwm duty compare block
`timescale 1ns/10ps
`default_nettype none
module pwmdc_top_tb;
   logic sys_clk, rst_n, wr_en, rd_en;
   logic [7:0] addr, wr_data, rd_data, v;
   logic [3:0] pwm_out, pwm_oe;
   int error_cnt = 0;
   int total_checks = 0;
   int h, t, d, p;
   logic [7:0] hd [4] = '{8'h00, 8'h28, 8'hFF, 8'h05};
   logic [7:0] hp [4] = '{8'h28, 8'h28, 8'h28, 8'h00};
   logic hl [4] = '{1'b0, 1'b1, 1'b1, 1'b1};

   pwmdc_top pwmdc_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .pwm_out(pwm_out), .pwm_oe(pwm_oe));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   function automatic int cyc(input int n, input int k);
      return n << k;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] dv);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= dv;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      @(negedge sys_clk);
      chk(rd_data, exp);
   endtask
   // bounded wait for a level; n is the count of cycles spent waiting
   task automatic wait_lvl(input int ch, input logic lvl, output int n);
      n = 0;
      while (pwm_out[ch] !== lvl && n < 9000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 9000) chk(1'b0, 1'b1);
   endtask
   // skips a cycle so stale buffers are gone, then times high part and period
   task automatic meas(input int ch, output int hi, output int per);
      int n;
      wait_lvl(ch, 1'b0, n);
      wait_lvl(ch, 1'b1, n);
      wait_lvl(ch, 1'b0, n);
      wait_lvl(ch, 1'b1, n);
      wait_lvl(ch, 1'b0, hi);
      wait_lvl(ch, 1'b1, n);
      per = hi + n;
   endtask
   // one 8-bit channel, start level high, restarted by a counter write
   // the match tick itself still shows the start level, so high is duty + 1
   task automatic run8(input int ch, input logic [7:0] ctl, input logic [7:0] pp,
                       input int pv, input int dv, input int k);
      wr(pwmdc_pkg::ADDR_CLK_JOIN, ctl);
      wr(pwmdc_pkg::ADDR_POL_PICK, pp);
      wr(pwmdc_pkg::ADDR_PERIOD0 + 8'(ch), 8'(pv));
      wr(pwmdc_pkg::ADDR_DUTY0 + 8'(ch), 8'(dv));
      wr(pwmdc_pkg::ADDR_ENABLE, 8'h0F);
      wr(pwmdc_pkg::ADDR_COUNTER0 + 8'(ch), 8'h00);
      meas(ch, h, t);
      chk(h, cyc(dv + 1, k));
      chk(t, cyc(pv + 1, k));
   endtask
   task automatic hold(input logic lvl);
      int bad;
      bad = 0;
      repeat (600) @(negedge sys_clk);
      repeat (300) begin
         @(negedge sys_clk);
         if (pwm_out[0] !== lvl) bad++;
      end
      chk(bad, 0);
   endtask
   task automatic results();
      if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // watchdog sized well above the expected run length
   initial begin
      repeat (95000) @(posedge sys_clk);
      error_cnt++;
      results();
   end
   initial begin
      rst_n = 1'b0;
      {wr_en, rd_en, addr, wr_data} = '0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      void'($urandom(32'h2EE7566F));
      for (int i = 0; i < 4; i++) rd(pwmdc_pkg::ADDR_DUTY0 + 8'(i), 8'hFF);
      rd(pwmdc_pkg::ADDR_CLK_JOIN, 8'h00);
      rd(8'h40, 8'h00);
      // random duty and control contents read back
      for (int i = 0; i < 8; i++) begin
         v = 8'($urandom);
         d = $urandom_range(3, 0);
         wr(pwmdc_pkg::ADDR_DUTY0 + 8'(d), v);
         rd(pwmdc_pkg::ADDR_DUTY0 + 8'(d), v);
         wr(pwmdc_pkg::ADDR_CLK_JOIN, v);
         rd(pwmdc_pkg::ADDR_CLK_JOIN, v & 8'hF7);
      end
      // every clock a code on channel 1, every clock b code on channel 3
      for (int k = 0; k < 8; k++) begin
         d = $urandom_range(8, 1);
         p = d + $urandom_range(8, 1);
         if (k < 4) run8(0, 8'(k << 4), 8'h01, p, d, k);
         run8(2, 8'(k), 8'h04, p, d, k);
      end
      // scaled clock on channel 1, scale one gives half rate
      wr(pwmdc_pkg::ADDR_SCALE, 8'h01);
      run8(0, 8'h00, 8'h11, 9, 4, 1);
      run8(3, 8'h00, 8'h08, 12, 7, 0);
      run8(1, 8'h00, 8'h02, 11, 3, 0);
      run8(0, 8'h00, 8'h01, 40, 10, 0);
      // duty rewritten mid-cycle only affects the following cycle
      wait_lvl(0, 1'b0, t);
      wait_lvl(0, 1'b1, t);
      fork
         wr(pwmdc_pkg::ADDR_DUTY0, 8'd30);
      join_none
      wait_lvl(0, 1'b0, h);
      chk(h, cyc(10 + 1, 0));
      wait_lvl(0, 1'b1, t);
      wait_lvl(0, 1'b0, h);
      chk(h, cyc(30 + 1, 0));
      // boundary levels: zero duty, duty at and above period, zero period
      for (int i = 0; i < 4; i++) begin
         wr(pwmdc_pkg::ADDR_PERIOD0, hp[i]);
         wr(pwmdc_pkg::ADDR_DUTY0, hd[i]);
         wr(pwmdc_pkg::ADDR_COUNTER0, 8'h00);
         hold(hl[i]);
      end
      // start level zero: zero period now holds the pin low
      wr(pwmdc_pkg::ADDR_POL_PICK, 8'h00);
      hold(1'b0);
      // joined 1/2: period 0x0101, duty 0x0100, high bytes first
      wr(pwmdc_pkg::ADDR_CLK_JOIN, 8'h40);
      wr(pwmdc_pkg::ADDR_POL_PICK, 8'h02);
      wr(8'h08, 8'h01);
      wr(8'h09, 8'h01);
      wr(8'h0C, 8'h01);
      wr(8'h0D, 8'h00);
      wr(8'h05, 8'h00);
      meas(1, h, t);
      chk(h, 257);
      chk(t, 258);
      chk(pwm_oe[1:0], 2'b10);
      // joined 3/4 on clock b: period 0x0100, duty 0x0081
      wr(pwmdc_pkg::ADDR_CLK_JOIN, 8'h80);
      wr(pwmdc_pkg::ADDR_POL_PICK, 8'h08);
      wr(8'h0A, 8'h01);
      wr(8'h0B, 8'h00);
      wr(8'h0E, 8'h00);
      wr(8'h0F, 8'h81);
      wr(8'h07, 8'h00);
      meas(3, h, t);
      chk(h, 130);
      chk(t, 257);
      chk(pwm_oe[3:2], 2'b10);
      results();
   end
endmodule

bind pwmdc_top pwmdc_top_chk pwmdc_top_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n),
   .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
   .pwm_out(pwm_out), .pwm_oe(pwm_oe));
`default_nettype wire
